// *** bench/dual_port_semaphore_flags_test.sv ***
// Self-checking bench for the token port controller
`timescale 1ns/1ns
`default_nettype none
module dual_port_semaphore_flags_test;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        cmd_valid = 1'b0;
	logic [1:0]  cmd_op = 2'h0;
	logic [2:0]  cmd_index = 3'h0;
	logic        cmd_value = 1'b0;
	logic        ready, rsp_valid, rsp_flag, rsp_owned, mem_en_n, sel_n, rw_n, oe_n, lane_n;
	logic        data_oe_n;
	logic [2:0]  tok_idx;
	logic [35:0] wr_data, rd_data;
	int          miscompares = 0;
	int          compares = 0;
	int          seed = 77;
	logic [1:0]  own_e [8];
	logic        ra_e [8];
	logic        rb_e [8];
	// An undriven data bus reaches the device inverted, so a missing enable shows
	wire  [35:0] bus_to_dev = data_oe_n ? ~wr_data : wr_data;

	tkc_port_ctrl #(.DATA_W(36)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(ready), .cmd_op_i(cmd_op),
		.cmd_index_i(cmd_index), .cmd_value_i(cmd_value), .rsp_valid_o(rsp_valid),
		.rsp_flag_o(rsp_flag), .rsp_owned_o(rsp_owned), .mem_enable_n_o(mem_en_n),
		.token_space_select_n_o(sel_n), .rw_n_o(rw_n), .output_enable_n_o(oe_n),
		.lowest_byte_lane_enable_n_o(lane_n), .token_index_o(tok_idx),
		.data_o(wr_data), .data_oe_n_o(data_oe_n), .data_i(rd_data));
	tkc_dev_model #(.DATA_W(36)) dev (.mem_enable_n_i(mem_en_n),
		.token_space_select_n_i(sel_n), .rw_n_i(rw_n), .output_enable_n_i(oe_n),
		.lowest_byte_lane_enable_n_i(lane_n), .token_index_i(tok_idx),
		.data_i(bus_to_dev), .data_o(rd_data));

	// Clock of 20 ns period
	initial forever #10 clk_sys_i = ~clk_sys_i;

	task automatic give_verdict;
		if (miscompares == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bench mirror of one token; b selects the far side
	task automatic mir(input bit b, input int i, input logic v);
		if (b) rb_e[i] = v;
		else ra_e[i] = v;
		case (own_e[i])
		2'h1: if (ra_e[i]) own_e[i] = rb_e[i] ? 2'h0 : 2'h2;
		2'h2: if (rb_e[i]) own_e[i] = ra_e[i] ? 2'h0 : 2'h1;
		default: own_e[i] = !ra_e[i] ? 2'h1 : (!rb_e[i] ? 2'h2 : 2'h0);
		endcase
	endtask
	function automatic logic exp_flag(input int i);
		return !(own_e[i] == 2'h1);
	endfunction
	task automatic far(input int i, input logic v);
		dev.far_write(i, v);
		mir(1'b1, i, v);
	endtask
	// One command: take, predict, then time and check the answer
	task automatic run(input logic [1:0] op, input logic [2:0] i, input logic v);
		int   n;
		logic e;
		n = 0;
		@(posedge clk_sys_i);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_index <= i;
		cmd_value <= v;
		do @(negedge clk_sys_i); while (ready !== 1'b1);
		@(posedge clk_sys_i);
		cmd_valid <= 1'b0;
		if (op == 2'h3) begin
			for (int k = 0; k < 8; k++) mir(1'b0, k, 1'b1);
			e = 1'b1;
		end else if (op == 2'h1) begin
			e = exp_flag(i);
		end else begin
			mir(1'b0, i, (op == 2'h2) ? 1'b0 : v);
			e = (op == 2'h2) ? exp_flag(i) : v;
		end
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (rsp_valid !== 1'b1 && n < 60);
		chk(36'(n), (op == 2'h3) ? 36'h30 : ((op == 2'h2) ? 36'hc : 36'h6));
		chk({35'h0, rsp_flag}, {35'h0, e});
		chk({35'h0, rsp_owned}, {35'h0, !e});
		chk({35'h0, mem_en_n}, 36'h1);
		@(posedge clk_sys_i);
		#1;
		chk({35'h0, rsp_valid}, 36'h0);
	endtask

	// Main sequence: power-up clear, handover corner case, then random traffic
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		run(2'h3, 3'h0, 1'b0);
		for (int k = 0; k < 8; k++) far(k, 1'b1);
		for (int k = 0; k < 8; k++) run(2'h1, 3'(k), 1'b0);
		far(5, 1'b0);
		run(2'h2, 3'h5, 1'b0);
		far(5, 1'b1);
		run(2'h1, 3'h5, 1'b0);
		far(5, 1'b0);
		run(2'h1, 3'h5, 1'b0);
		run(2'h0, 3'h5, 1'b1);
		run(2'h1, 3'h5, 1'b0);
		far(5, 1'b1);
		run(2'h2, 3'h5, 1'b0);
		run(2'h0, 3'h5, 1'b1);
		for (int k = 0; k < 60; k++) begin
			if ($random(seed) & 1) far(int'($unsigned($random(seed)) % 8), 1'($random(seed)));
			run(2'($unsigned($random(seed)) % 3), 3'($random(seed)), 1'($random(seed)));
		end
		give_verdict;
	end
	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		miscompares++;
		give_verdict;
	end
endmodule
`default_nettype wire

// *** bench/tkc_dev_model.sv ***
// Device model: eight token latches, near port on pins, far port by task
`timescale 1ns/1ns
`default_nettype none
module tkc_dev_model #(
	parameter int DATA_W = 36
) (
	input  wire logic              mem_enable_n_i,
	input  wire logic              token_space_select_n_i,
	input  wire logic              rw_n_i,
	input  wire logic              output_enable_n_i,
	input  wire logic              lowest_byte_lane_enable_n_i,
	input  wire logic [2:0]        token_index_i,
	input  wire logic [DATA_W-1:0] data_i,
	output logic      [DATA_W-1:0] data_o
);
	// eight latches, unknown until ones are written
	logic [1:0] own [8];
	logic       req_a [8];
	logic       req_b [8];
	logic       rd_lat;
	logic       wr_go;
	logic [2:0] wr_idx;
	logic       wr_bit;
	// selected only with memory enable high and select low
	wire        sel = !token_space_select_n_i && mem_enable_n_i;
	// one owner; a release hands over to a waiter
	task automatic upd(input int i);
		case (own[i])
		2'h1: if (req_a[i]) own[i] = req_b[i] ? 2'h0 : 2'h2;
		2'h2: if (req_b[i]) own[i] = req_a[i] ? 2'h0 : 2'h1;
		default: own[i] = !req_a[i] ? 2'h1 : (!req_b[i] ? 2'h2 : 2'h0);
		endcase
	endtask
	// Far port write, issued by the bench between near accesses
	task automatic far_write(input int i, input logic v);
		req_b[i] = v;
		upd(i);
	endtask
	// pulse start captures index and bit 0, end commits
	always @(negedge rw_n_i) begin
		wr_go = sel;
		wr_idx = token_index_i;
		wr_bit = data_i[0];
	end
	always @(posedge rw_n_i) begin
		if (wr_go) begin
			req_a[wr_idx] = wr_bit;
			upd(wr_idx);
		end
	end
	// frozen once the read goes active, spread on all bits
	wire rd_act = sel && rw_n_i && !output_enable_n_i && !lowest_byte_lane_enable_n_i;
	always @(posedge rd_act) begin
		#1;
		rd_lat = !(own[token_index_i] == 2'h1);
	end
	// No wait states; a released bus shows the inverse, not the last value
	assign data_o = rd_act ? {DATA_W{rd_lat}} : {DATA_W{!rd_lat}};
endmodule
`default_nettype wire

// *** verilog/tkc_defines.svh ***
// Constants for the token semaphore port controller
`ifndef TKC_DEFINES_SVH
`define TKC_DEFINES_SVH
// Number of token latches and index width
`define TKC_TOKENS      8
`define TKC_IDX_W       3
// Port data width
`define TKC_DATA_W      36
// Address setup time before strobe, ns, and the derived cycle count
`define TKC_T_SETUP_NS  20
`define TKC_CLK_NS      20
`define TKC_SETUP_CYC   ((`TKC_T_SETUP_NS + `TKC_CLK_NS - 1) / `TKC_CLK_NS)
// Strobe (write pulse / read access) width, ns, and derived cycles
`define TKC_T_STROBE_NS 40
`define TKC_STROBE_CYC  ((`TKC_T_STROBE_NS + `TKC_CLK_NS - 1) / `TKC_CLK_NS)
// Idle gap that deasserts select between accesses, ns, and cycles
`define TKC_T_GAP_NS    20
`define TKC_GAP_CYC     ((`TKC_T_GAP_NS + `TKC_CLK_NS - 1) / `TKC_CLK_NS)
// Width of the phase counter
`define TKC_CNT_W       4
`endif

// *** verilog/tkc_pkg.sv ***
// Types for the token semaphore port controller
package tkc_pkg;
	typedef enum logic [2:0] {
		TKC_IDLE,
		TKC_SETUP,
		TKC_STROBE,
		TKC_GAP
	} tkc_state_e;
	typedef enum logic [1:0] {
		TKC_OP_WRITE,
		TKC_OP_READ,
		TKC_OP_ACQUIRE,
		TKC_OP_INIT
	} tkc_op_e;
endpackage

// *** verilog/tkc_port_ctrl.sv ***
// Host-side controller driving one port's token-latch pins of a dual-port memory
//
// Behaviour
// [RL1] Device holds eight token latches apart from the memory array.
// [RL2] Token access uses token select low with address, enables, read/write as SRAM.
// [RL3] Only the three lowest address lines pick the token.
// [RL4] Device uses only data bit zero on a token write.
// [RL5] Write zero requests a token, write one from same port releases.
// [RL6] Zero to a free token reads zero here, one on the other port.
// [RL7] Only the owner can change an owned token; its one frees it.
// [RL8] Non-owner zero waits in its request latch until release.
// [RL9] Pending request takes ownership at once on release, until it writes one.
// [RL10] Token read replicates the flag on all data bits.
// [RL11] Read value is latched when select, lane enable and output enable go active.
// [RL12] Lane enable only gates outputs during token reads.
// [RL13] Polling must drop token select or output enable between reads.
// [RL14] Simultaneous requests go to exactly one port; earlier wins.
// [RL15] Tokens gate nothing in hardware and insert no wait states.
// [RL16] Acquire by writing zero then reading back, never read first.
// [RL17] After a failed request keep reading or write one to withdraw.
// [RL18] Software writes one to every token at power-up from both ports.
// [RL19] Port with memory enable and token select inactive is in standby.
// [RL20] Token access needs memory enable high and token select low together.
// [RL21] Power-up latch contents are unknown until ones are written.
`timescale 1ns/1ns
`default_nettype none
`include "tkc_defines.svh"

module tkc_port_ctrl
	import tkc_pkg::*;
#(
	parameter int DATA_W = `TKC_DATA_W
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_n_i,
	// Command side
	input  wire logic                  cmd_valid_i,
	output logic                       cmd_ready_o,
	input  wire logic [1:0]            cmd_op_i,
	input  wire logic [`TKC_IDX_W-1:0] cmd_index_i,
	input  wire logic                  cmd_value_i,
	output logic                       rsp_valid_o,
	output logic                       rsp_flag_o,
	output logic                       rsp_owned_o,
	// Device pins
	output logic                       mem_enable_n_o,
	output logic                       token_space_select_n_o,
	output logic                       rw_n_o,
	output logic                       output_enable_n_o,
	output logic                       lowest_byte_lane_enable_n_o,
	output logic [`TKC_IDX_W-1:0]      token_index_o,
	output logic [DATA_W-1:0]          data_o,
	output logic                       data_oe_n_o,
	input  wire logic [DATA_W-1:0]     data_i
);

	// ******************************************************************
	// Elaboration checks
	// ******************************************************************
	// Upper-lane idle check needs a bit above bit zero
	if (DATA_W < 2)
		$error("DATA_W must be at least two");

	// ******************************************************************
	// State
	// ******************************************************************
	typedef struct packed {
		tkc_state_e            st;
		logic [`TKC_CNT_W-1:0] cnt;
		logic                  wr;       // Current access is a write
		logic                  val;      // Bit written
		logic [`TKC_IDX_W-1:0] idx;
		logic [1:0]            op;
		logic                  again;    // Acquire: readback still to do
		logic [`TKC_IDX_W:0]   init_n;   // Init: tokens left to release
		logic                  rsp_v;
		logic                  rsp_f;
		logic [DATA_W-1:0]     dq;
		logic                  strobe;
		logic [DATA_W-1:0]     din1;
		logic [DATA_W-1:0]     din2;
	} tkc_state_s;

	tkc_state_s cur_ff;
	tkc_state_s nxt_ff;

	// ******************************************************************
	// Next state
	// ******************************************************************
	// Sequencer: setup, strobe, gap; the gap always deasserts select
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.rsp_v = 1'b0;
		// Data pins pass two flops before use
		nxt_ff.din1 = data_i;
		nxt_ff.din2 = cur_ff.din1;
		case (cur_ff.st)
			TKC_IDLE: begin
				if (cmd_valid_i) begin
					nxt_ff.op = cmd_op_i;
					nxt_ff.idx = cmd_index_i;
					nxt_ff.again = 1'b0;
					nxt_ff.init_n = '0;
					// [RL16] Acquire writes zero first
					case (tkc_op_e'(cmd_op_i))
						// [RL17] Write one withdraws a failed request
						TKC_OP_WRITE: begin
							nxt_ff.wr = 1'b1;
							nxt_ff.val = cmd_value_i;
						end
						TKC_OP_READ: begin
							nxt_ff.wr = 1'b0;
							nxt_ff.val = 1'b1;
						end
						// [RL5] Zero requests the token
						TKC_OP_ACQUIRE: begin
							nxt_ff.wr = 1'b1;
							nxt_ff.val = 1'b0;
							nxt_ff.again = 1'b1;
						end
						// [RL18] Release all tokens at start-up
						default: begin
							nxt_ff.wr = 1'b1;
							nxt_ff.val = 1'b1;
							nxt_ff.idx = '0;
							nxt_ff.init_n = (`TKC_IDX_W+1)'(`TKC_TOKENS - 1);
						end
					endcase
					nxt_ff.st = TKC_SETUP;
					nxt_ff.cnt = `TKC_CNT_W'(`TKC_SETUP_CYC - 1);
				end
			end
			TKC_SETUP: begin
				if (cur_ff.cnt == '0) begin
					nxt_ff.st = TKC_STROBE;
					nxt_ff.cnt = `TKC_CNT_W'(`TKC_STROBE_CYC - 1);
				end else begin
					nxt_ff.cnt = cur_ff.cnt - 1'b1;
				end
			end
			TKC_STROBE: begin
				if (cur_ff.cnt == '0) begin
					nxt_ff.st = TKC_GAP;
					// Sample the data one stage late through the synchroniser
					nxt_ff.cnt = `TKC_CNT_W'(`TKC_GAP_CYC + 1);
				end else begin
					nxt_ff.cnt = cur_ff.cnt - 1'b1;
				end
			end
			TKC_GAP: begin
				if (cur_ff.cnt == '0) begin
					if (cur_ff.again) begin
						// [RL16] Read back after the request
						nxt_ff.again = 1'b0;
						nxt_ff.wr = 1'b0;
						nxt_ff.st = TKC_SETUP;
						nxt_ff.cnt = `TKC_CNT_W'(`TKC_SETUP_CYC - 1);
					end else if (cur_ff.init_n != '0) begin
						nxt_ff.init_n = cur_ff.init_n - 1'b1;
						nxt_ff.idx = cur_ff.idx + 1'b1;
						nxt_ff.st = TKC_SETUP;
						nxt_ff.cnt = `TKC_CNT_W'(`TKC_SETUP_CYC - 1);
					end else begin
						nxt_ff.st = TKC_IDLE;
						nxt_ff.rsp_v = 1'b1;
					end
				end else begin
					// [RL10] Owned when every returned bit reads zero
					if (!cur_ff.wr && cur_ff.cnt == `TKC_CNT_W'(`TKC_GAP_CYC))
						nxt_ff.rsp_f = |cur_ff.din2;
					if (cur_ff.wr)
						nxt_ff.rsp_f = cur_ff.val;
					nxt_ff.cnt = cur_ff.cnt - 1'b1;
				end
			end
			default: nxt_ff.st = TKC_IDLE;
		endcase
		// Register pin drive for the coming cycle
		nxt_ff.strobe = (nxt_ff.st == TKC_STROBE);
		nxt_ff.dq = {DATA_W{1'b1}};
		// [RL4] Only bit zero carries the written value
		nxt_ff.dq[0] = nxt_ff.val;
	end

	// ******************************************************************
	// Registers
	// ******************************************************************
	// [RL21] Controller has a known state; latch contents stay software's job
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cur_ff <= '0;
			cur_ff.st <= TKC_IDLE;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// ******************************************************************
	// Pins
	// ******************************************************************
	wire active = (cur_ff.st != TKC_IDLE) && (cur_ff.st != TKC_GAP);
	// [RL20] Memory enable held high for every access
	assign mem_enable_n_o = 1'b1;
	// [RL13] Select drops in the gap, so each read relatches
	assign token_space_select_n_o = !active;
	// [RL19] Idle leaves both enables high: standby
	assign rw_n_o = !(cur_ff.wr && cur_ff.strobe);
	// [RL11] Output enable with lane enable opens the device latch
	assign output_enable_n_o = !(!cur_ff.wr && active);
	// [RL2] Lane zero enabled throughout the access
	assign lowest_byte_lane_enable_n_o = !active;
	// [RL3] Only the token index drives the address
	assign token_index_o = cur_ff.idx;
	assign data_o = cur_ff.dq;
	assign data_oe_n_o = !(cur_ff.wr && active);
	// [RL15] No wait input: each access has a fixed length
	assign cmd_ready_o = (cur_ff.st == TKC_IDLE);
	assign rsp_valid_o = cur_ff.rsp_v;
	assign rsp_flag_o = cur_ff.rsp_f;
	// [RL6] Zero read back means this port owns it
	assign rsp_owned_o = !cur_ff.rsp_f;

	// ******************************************************************
	// Assertions
	// ******************************************************************
	property p_standby;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		cmd_ready_o |-> token_space_select_n_o && mem_enable_n_o;
	endproperty
	a_standby: assert property (p_standby) else $error("select active while idle"); // [RL19]

	property p_gap;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(token_space_select_n_o) |-> token_space_select_n_o [*3];
	endproperty
	a_gap: assert property (p_gap) else $error("select gap too short"); // [RL13]

	property p_acq;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cmd_ready_o && cmd_valid_i && tkc_op_e'(cmd_op_i) == TKC_OP_ACQUIRE)
			|-> ##2 !rw_n_o ##[1:8] !output_enable_n_o;
	endproperty
	a_acq: assert property (p_acq) else $error("acquire not write then read"); // [RL16]

	property p_d0;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!data_oe_n_o |-> data_o[DATA_W-1:1] == {(DATA_W-1){1'b1}};
	endproperty
	a_d0: assert property (p_d0) else $error("upper data not idle high"); // [RL4]

	property p_mem;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!token_space_select_n_o |-> mem_enable_n_o && !lowest_byte_lane_enable_n_o;
	endproperty
	a_mem: assert property (p_mem) else $error("bad enable pairing"); // [RL20]

	property p_oe;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!output_enable_n_o |-> data_oe_n_o && rw_n_o;
	endproperty
	a_oe: assert property (p_oe) else $error("drive clash on read"); // [RL11]

	property p_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(token_space_select_n_o) |-> !token_space_select_n_o [*3] ##1 token_space_select_n_o;
	endproperty
	a_len: assert property (p_len) else $error("access length wrong"); // [RL15]

	property p_rsp;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rsp_valid_o |-> cmd_ready_o && (rsp_owned_o != rsp_flag_o);
	endproperty
	a_rsp: assert property (p_rsp) else $error("answer inconsistent"); // [RL6]

endmodule

`default_nettype wire
